// ---- csctl_counter.v ----
`timescale 1ns/100ps
`include "csctl_consts.vh"

module csctl_counter (
    input  wire       clk,
    input  wire       srst,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       counter_input,
    input  wire       sense_interrupt,
    input  wire       pseudo_random_sequence_output,
    input  wire       slow_32k_clock,
    input  wire       timer_clock_choice,
    input  wire       timer_one_start,
    output wire       prescaled_main_clock,
    output wire       switch_clock_en,
    output wire       sense_counter_tick,
    output wire       timer_one_tick,
    output wire       sense_start,
    output wire       counting,
    output wire       low_counter_output,
    output wire       high_counter_output,
    output reg        pin_out
);

    // ----------------------------------------
    // Local states
    // ----------------------------------------
    localparam [1:0] ST_OFF   = 2'h0;
    localparam [1:0] ST_ARM   = 2'h1;
    localparam [1:0] ST_COUNT = 2'h2;
    localparam [1:0] ST_DONE  = 2'h3;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg  [7:0]  ctrl_q;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [15:0] count_q;
    reg  [3:0]  pre_cnt_q;
    reg  [3:0]  div_cnt_q;
    reg         in_s1_q;
    reg         in_s2_q;
    reg         in_prev_q;
    reg         int_s1_q;
    reg         int_s2_q;
    reg         slw_s1_q;
    reg         slw_s2_q;
    reg         slw_prev_q;
    reg         pre_tick_q;
    wire        enable;
    wire        smode;
    wire [1:0]  mode;
    wire [1:0]  pin_sel;
    wire        in_rise;
    wire        in_fall;
    wire        slw_rise;
    wire        src_tick;
    wire        div_tick;
    wire        ctrl_wr;
    wire        rearm;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [3:0] wrap_inc;
        input [3:0] cur;
        input [3:0] lim;
        begin
            if (cur >= lim - 4'h1) begin
                wrap_inc = 4'h0;
            end else begin
                wrap_inc = cur + 4'h1;
            end
        end
    endfunction

    function is_last;
        input [3:0] cur;
        input [3:0] lim;
        begin
            is_last = (cur >= lim - 4'h1);
        end
    endfunction

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    assign enable  = ctrl_q[`CSCTL_EN_BIT];
    assign smode   = ctrl_q[`CSCTL_SMODE_BIT];
    assign mode    = ctrl_q[`CSCTL_MODE_HI:`CSCTL_MODE_LO];
    assign pin_sel = ctrl_q[`CSCTL_SEL_HI:`CSCTL_SEL_LO];
    assign ctrl_wr = reg_wr && (reg_addr == `CSCTL_OFS_CONTROL);
    // Writing the control word with enable set re-arms a stopped counter
    assign rearm   = ctrl_wr && reg_wdata[`CSCTL_EN_BIT];

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    // all eight bits written on every control write
    // Bits 7:1 are not guarded; changing them while enabled is undefined
    always @(posedge clk) begin
        if (srst) begin
            ctrl_q <= `CSCTL_CONTROL_RST;
        end else if (ctrl_wr) begin
            ctrl_q <= reg_wdata;
        end
    end

    // low byte read
    // Writes to the count offset fall through and change nothing
    always @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CSCTL_OFS_CONTROL: begin
                    reg_rdata <= ctrl_q;
                end
                `CSCTL_OFS_COUNT_LO: begin
                    reg_rdata <= count_q[7:0];
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            in_s1_q    <= 1'b0;
            in_s2_q    <= 1'b0;
            in_prev_q  <= 1'b0;
            int_s1_q   <= 1'b0;
            int_s2_q   <= 1'b0;
            slw_s1_q   <= 1'b0;
            slw_s2_q   <= 1'b0;
            slw_prev_q <= 1'b0;
        end else begin
            in_s1_q    <= counter_input;
            in_s2_q    <= in_s1_q;
            in_prev_q  <= in_s2_q;
            int_s1_q   <= sense_interrupt;
            int_s2_q   <= int_s1_q;
            slw_s1_q   <= slow_32k_clock;
            slw_s2_q   <= slw_s1_q;
            slw_prev_q <= slw_s2_q;
        end
    end

    assign in_rise  = in_s2_q && !in_prev_q;
    assign in_fall  = !in_s2_q && in_prev_q;
    assign slw_rise = slw_s2_q && !slw_prev_q;

    // ----------------------------------------
    // Prescaled main clock
    // ----------------------------------------
    // free running
    // Runs from reset, so sensing mode can never halt or restart its phase
    always @(posedge clk) begin
        if (srst) begin
            pre_cnt_q  <= 4'h0;
            pre_tick_q <= 1'b0;
        end else begin
            pre_cnt_q  <= wrap_inc(pre_cnt_q, `CSCTL_PRESCALE_DIV);
            pre_tick_q <= is_last(pre_cnt_q, `CSCTL_PRESCALE_DIV);
        end
    end

    assign prescaled_main_clock = pre_tick_q;

    assign switch_clock_en = ctrl_q[`CSCTL_SWCLK_BIT] ?
                             pseudo_random_sequence_output : pre_tick_q;

    // ----------------------------------------
    // Counter clock divider
    // ----------------------------------------
    // divider source
    assign src_tick = ctrl_q[`CSCTL_SRC_BIT] ? pre_tick_q : 1'b1;

    always @(posedge clk) begin
        if (srst || !enable) begin
            div_cnt_q <= 4'h0;
        end else if (src_tick) begin
            div_cnt_q <= wrap_inc(div_cnt_q, `CSCTL_COUNT_DIV);
        end
    end

    assign div_tick = src_tick && smode && enable &&
                      is_last(div_cnt_q, `CSCTL_COUNT_DIV);
    assign sense_counter_tick = div_tick;

    // ----------------------------------------
    // Timer one clock and start
    // ----------------------------------------
    // timer on prescaled in sensing mode
    assign timer_one_tick = smode ? pre_tick_q :
                            (timer_clock_choice ? slw_rise : 1'b1);

    assign sense_start = smode && timer_one_start;

    // ----------------------------------------
    // Counting sequence
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (enable) begin
                    if (mode == `CSCTL_MODE_EVENT ||
                        mode == `CSCTL_MODE_CONT) begin
                        state_d = ST_COUNT;
                    end else begin
                        state_d = ST_ARM;
                    end
                end
            end
            ST_ARM: begin
                if (in_rise) begin
                    state_d = ST_COUNT;
                end
            end
            ST_COUNT: begin
                case (mode)
                    `CSCTL_MODE_EVENT: begin
                        if (int_s2_q) begin
                            state_d = ST_DONE;
                        end
                    end
                    `CSCTL_MODE_PULSE: begin
                        if (in_fall) begin
                            state_d = ST_DONE;
                        end
                    end
                    `CSCTL_MODE_PERIOD: begin
                        if (in_rise) begin
                            state_d = ST_DONE;
                        end
                    end
                    default: begin
                        state_d = ST_COUNT;
                    end
                endcase
            end
            ST_DONE: begin
                if (rearm) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        if (!enable) begin
            state_d = ST_OFF;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // Count register
    // ----------------------------------------
    // zero when disabled
    // stable after stop
    // A re-arm from the stopped state starts a fresh count from zero
    always @(posedge clk) begin
        if (srst || !enable) begin
            count_q <= 16'h0000;
        end else if (state_q == ST_DONE && rearm) begin
            count_q <= 16'h0000;
        end else if (state_q == ST_COUNT && div_tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    assign counting            = (state_q == ST_COUNT);
    assign low_counter_output  = count_q[7];
    assign high_counter_output = count_q[15];

    // ----------------------------------------
    // Output pin routing
    // ----------------------------------------
    // pin select
    // Registered to keep the pin glitch free while the select changes
    always @(posedge clk) begin
        if (srst) begin
            pin_out <= 1'b0;
        end else begin
            case (pin_sel)
                `CSCTL_PIN_INPUT: begin
                    pin_out <= in_s2_q;
                end
                `CSCTL_PIN_SENSE: begin
                    pin_out <= int_s2_q;
                end
                `CSCTL_PIN_LOW: begin
                    pin_out <= count_q[7];
                end
                `CSCTL_PIN_HIGH: begin
                    pin_out <= count_q[15];
                end
                default: begin
                    pin_out <= 1'b0;
                end
            endcase
        end
    end

endmodule

// ---- csctl_consts.vh ----
`ifndef CSCTL_CONSTS_VH
`define CSCTL_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CSCTL_OFS_CONTROL   8'ha0
`define CSCTL_OFS_COUNT_LO  8'ha4
`define CSCTL_CONTROL_RST   8'h00

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CSCTL_SEL_HI        7
`define CSCTL_SEL_LO        6
`define CSCTL_SWCLK_BIT     5
`define CSCTL_SRC_BIT       4
`define CSCTL_SMODE_BIT     3
`define CSCTL_MODE_HI       2
`define CSCTL_MODE_LO       1
`define CSCTL_EN_BIT        0

// ----------------------------------------
// Counter modes and pin selects
// ----------------------------------------
`define CSCTL_MODE_EVENT    2'h0
`define CSCTL_MODE_PULSE    2'h1
`define CSCTL_MODE_PERIOD   2'h2
`define CSCTL_MODE_CONT     2'h3
`define CSCTL_PIN_INPUT     2'h0
`define CSCTL_PIN_SENSE     2'h1
`define CSCTL_PIN_LOW       2'h2
`define CSCTL_PIN_HIGH      2'h3

// ----------------------------------------
// Divider counts: prescaler in clk cycles, counter divider in source ticks
// ----------------------------------------
`define CSCTL_PRESCALE_DIV  4'h4
`define CSCTL_COUNT_DIV     4'h2

`endif

// ---- csctl_counter_monitor.sv ----
`timescale 1ns/100ps
`include "csctl_consts.vh"
module csctl_counter_monitor (
    input wire       clk,
    input wire       srst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       pseudo_random_sequence_output,
    input wire       timer_clock_choice,
    input wire       timer_one_start,
    input wire       prescaled_main_clock,
    input wire       switch_clock_en,
    input wire       sense_counter_tick,
    input wire       timer_one_tick,
    input wire       sense_start,
    input wire       counting
);
    reg [7:0] ctl_q;
    // Shadow of the control register, rebuilt from bus writes
    always @(posedge clk) begin
        if (srst) begin
            ctl_q <= 8'h00;
        end else if (reg_wr && reg_addr == `CSCTL_OFS_CONTROL) begin
            ctl_q <= reg_wdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_ctl_readback: assert property (reg_rd && reg_addr == `CSCTL_OFS_CONTROL |=> reg_rdata == $past(ctl_q))
        else $error("control readback wrong");
    a_swclk_prs: assert property (ctl_q[5] |-> switch_clock_en == pseudo_random_sequence_output)
        else $error("switch clock not from sequence");
    a_swclk_pre: assert property (!ctl_q[5] |-> switch_clock_en == prescaled_main_clock)
        else $error("switch clock not prescaled");
    a_pre_period: assert property ($rose(prescaled_main_clock) |=> !prescaled_main_clock [*3] ##1 prescaled_main_clock)
        else $error("prescaled clock not free running");
    a_timer_pre: assert property (ctl_q[3] |-> timer_one_tick == prescaled_main_clock)
        else $error("timer one not on prescaled clock");
    a_timer_cpu: assert property (!ctl_q[3] && !timer_clock_choice |-> timer_one_tick)
        else $error("timer one not on processor clock");
    a_start_gate: assert property (sense_start == (ctl_q[3] && timer_one_start))
        else $error("start signal gating wrong");
    a_tick_gate: assert property (sense_counter_tick |-> ctl_q[0] && ctl_q[3])
        else $error("counter ticks while halted");
    a_tick_space: assert property (sense_counter_tick |=> !sense_counter_tick)
        else $error("counter ticks too close");
    a_off_idle: assert property (!ctl_q[0] && !$past(ctl_q[0]) |-> !counting)
        else $error("counting while disabled");
    c_stop: cover property ($fell(counting));
    c_count_rd: cover property (reg_rd && reg_addr == `CSCTL_OFS_COUNT_LO);
    c_start: cover property (sense_start);
endmodule
bind csctl_counter csctl_counter_monitor mon (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pseudo_random_sequence_output(pseudo_random_sequence_output), .timer_clock_choice(timer_clock_choice),
    .timer_one_start(timer_one_start), .prescaled_main_clock(prescaled_main_clock),
    .switch_clock_en(switch_clock_en), .sense_counter_tick(sense_counter_tick), .timer_one_tick(timer_one_tick),
    .sense_start(sense_start), .counting(counting));

// ---- csctl_front_model.sv ----
`timescale 1ns/100ps
// Comparator front end: drives the counter input and the sense event
module csctl_front_model (
    input  wire clk,
    output reg  counter_input,
    output reg  sense_interrupt
);
    initial counter_input = 1'b0;
    initial sense_interrupt = 1'b0;
    task set(input a, input b);
        begin
            counter_input <= a;
            sense_interrupt <= b;
            @(posedge clk);
        end
    endtask
    // Symmetric pulse: high n cycles, then low n cycles
    task pulse(input integer n);
        begin
            counter_input <= 1'b1;
            repeat (n) @(posedge clk);
            counter_input <= 1'b0;
            repeat (n) @(posedge clk);
        end
    endtask
endmodule

// ---- test_capsense_counter_control.sv ----
`timescale 1ns/100ps
`include "csctl_consts.vh"
module test_capsense_counter_control;
    reg        clk = 1'b0;
    reg        srst = 1'b1;
    reg        reg_wr = 1'b0;
    reg        reg_rd = 1'b0;
    reg        prs_q = 1'b0;
    reg        tsel = 1'b0;
    reg        tstart = 1'b0;
    reg        slw = 1'b0;
    reg  [7:0] reg_addr = 8'h00;
    reg  [7:0] reg_wdata = 8'h00;
    reg  [7:0] v;
    reg  [7:0] w;
    wire [7:0] reg_rdata;
    wire       cin, cint, pmc, swe, sct, t1t, sst, counting, lco, hco, pin_out;
    integer    error_cnt = 0;
    integer    tests_run = 0;
    integer    i;
    integer    s;
    always #50 clk = ~clk;
    always @(posedge clk) prs_q <= ~prs_q;
    csctl_front_model fe (.clk(clk), .counter_input(cin), .sense_interrupt(cint));
    csctl_counter uut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .counter_input(cin), .sense_interrupt(cint),
        .pseudo_random_sequence_output(prs_q), .slow_32k_clock(slw), .timer_clock_choice(tsel),
        .timer_one_start(tstart), .prescaled_main_clock(pmc), .switch_clock_en(swe), .sense_counter_tick(sct),
        .timer_one_tick(t1t), .sense_start(sst), .counting(counting), .low_counter_output(lco),
        .high_counter_output(hco), .pin_out(pin_out));
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task chk(input [7:0] sn, input [7:0] ex);
        begin
            tests_run = tests_run + 1;
            if (sn !== ex) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t seen %h want %h", $time, sn, ex);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 d = reg_rdata;
            @(posedge clk);
        end
    endtask
    task rchk(input [7:0] a, input [7:0] ex);
        begin
            rd(a, v);
            chk(v, ex);
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task near(input integer ex);
        begin
            i = 0;
            while (counting !== 1'b0 && i < 400) begin
                @(posedge clk);
                #1 i = i + 1;
            end
            if (i >= 400) begin
                error_cnt = error_cnt + 1;
                results;
            end
            rd(`CSCTL_OFS_COUNT_LO, v);
            chk({7'h0, (v + 2 >= ex) && (v <= ex + 2)}, 8'h01);
        end
    endtask
    // Bounded wait for the routed pin to rise; i counts the cycles waited
    task pin_wait(input integer lim);
        begin
            #1 i = 0;
            while (pin_out !== 1'b1 && i < lim) begin
                @(posedge clk);
                #1 i = i + 1;
            end
            if (i >= lim) begin
                error_cnt = error_cnt + 1;
                results;
            end
        end
    endtask
    // ----------------------------------------
    // Sequence; control only rewritten while disabled, or with 00 to disable
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rchk(8'ha0, 8'h00);
        rchk(8'ha4, 8'h00);
        rchk(8'h55, 8'h00);
        wr(8'ha0, 8'hf6);
        rchk(8'ha0, 8'hf6);
        repeat (20) @(posedge clk);
        rchk(8'ha4, 8'h00);
        $display("test registers done");
        fe.set(1'b1, 1'b1);
        for (s = 0; s < 4; s = s + 1) begin
            wr(8'ha0, {s[1:0], 6'h00});
            repeat (5) @(posedge clk);
            #1 chk({7'h0, pin_out}, (s < 2) ? 8'h01 : 8'h00);
        end
        fe.set(1'b0, 1'b0);
        wr(8'ha0, 8'h00);
        #1 chk({7'h0, t1t}, 8'h01);
        tsel <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({7'h0, t1t}, 8'h00);
        slw <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({7'h0, t1t}, 8'h01);
        @(posedge clk);
        #1 chk({7'h0, t1t}, 8'h00);
        tsel <= 1'b0;
        tstart <= 1'b1;
        wr(8'ha0, 8'h28);
        #1 chk({7'h0, sst}, 8'h01);
        tstart <= 1'b0;
        wr(8'ha0, 8'h00);
        $display("test routing done");
        wr(8'ha0, 8'h09);
        repeat (40) @(posedge clk);
        fe.set(1'b0, 1'b1);
        near(21);
        rd(8'ha4, w);
        wr(8'ha4, 8'hff);
        repeat (20) @(posedge clk);
        rchk(8'ha4, w);
        fe.set(1'b0, 1'b0);
        wr(8'ha0, 8'h00);
        rchk(8'ha4, 8'h00);
        wr(8'ha0, 8'h0b);
        repeat (6) @(posedge clk);
        fe.pulse(40);
        near(20);
        wr(8'ha0, 8'h00);
        wr(8'ha0, 8'h0d);
        repeat (6) @(posedge clk);
        fe.pulse(15);
        fe.pulse(15);
        near(15);
        wr(8'ha0, 8'h00);
        wr(8'ha0, 8'h1b);
        repeat (6) @(posedge clk);
        fe.pulse(80);
        near(10);
        wr(8'ha0, 8'h00);
        $display("test modes done");
        wr(8'ha0, 8'h0f);
        fe.set(1'b0, 1'b1);
        repeat (60) @(posedge clk);
        #1 chk({7'h0, counting}, 8'h01);
        fe.set(1'b0, 1'b0);
        wr(8'ha0, 8'h00);
        #1 chk({7'h0, counting}, 8'h00);
        rchk(8'ha4, 8'h00);
        wr(8'ha0, 8'h8f);
        pin_wait(320);
        chk({7'h0, (i + 2 >= 128 * `CSCTL_COUNT_DIV) && (i <= 128 * `CSCTL_COUNT_DIV + 2)}, 8'h01);
        chk({6'h0, lco, hco}, 8'h02);
        wr(8'ha0, 8'h00);
        wr(8'ha0, 8'hcf);
        pin_wait(66000);
        chk({7'h0, (i + 2 >= 32768 * `CSCTL_COUNT_DIV) && (i <= 32768 * `CSCTL_COUNT_DIV + 2)}, 8'h01);
        chk({7'h0, hco}, 8'h01);
        wr(8'ha0, 8'h00);
        $display("test continuous done");
        results;
    end
endmodule
